// ==== verilog/cce_consts.svh ====
// offsets, opcodes, reset values and cycle counts of the execution core
`ifndef CCE_CONSTS_SVH
`define CCE_CONSTS_SVH
`define CCE_OFF_CTRL 12'h000
`define CCE_OFF_STATUS 12'h004
`define CCE_OFF_PC 12'h008
`define CCE_OFF_CLKMODE 12'h00C
`define CCE_OFF_RAM_ADDR 12'h010
`define CCE_OFF_RAM_DATA 12'h014
`define CCE_CTRL_RUN 0
`define CCE_CTRL_STEP 1
`define CCE_OP_JAL 6'h17
`define CCE_OP_MODE_SET 6'h03
`define CCE_OP_UCOMP 6'h21
`define CCE_OP_SCOMP 6'h30
`define CCE_CLK_MODE_RST 8'h00
`define CCE_PC_RST 9'h000
`define CCE_ALU_CLKS 5'h04
`define CCE_HUB_MIN_CLKS 5'h08
`define CCE_ALU_LAST_CNT (`CCE_ALU_CLKS - 5'h01)
`define CCE_HUB_LAST_CNT (`CCE_HUB_MIN_CLKS - 5'h01)
`define CCE_CNT_MAX 5'h1F
`endif

// ==== verilog/cce_pkg.sv ====
// types of the execution core
package cce_pkg;
  typedef enum logic {
    CCE_IDLE,
    CCE_EXEC
  } cce_state_e;
  typedef struct packed {
    logic [5:0] op;
    logic upd_z;
    logic upd_c;
    logic store_res;
    logic imm;
    logic [3:0] cond;
    logic [8:0] dst;
    logic [8:0] src;
  } cce_instr_s;
endpackage : cce_pkg

// ==== verilog/cce_exec_core.sv ====
// execution core for call, clock-mode set and compare instructions
`timescale 1ns/1ps
`include "cce_consts.svh"
module cce_exec_core (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // hub window
  input wire logic hub_grant,
  output logic hub_req,
  // clock mode
  output logic [7:0] clk_mode
);
  logic [31:0] ram [0:511];
  cce_pkg::cce_state_e state_reg;
  cce_pkg::cce_instr_s ir_reg;
  logic [8:0] pc_reg;
  logic [4:0] cnt_reg;
  logic z_reg;
  logic c_reg;
  logic run_reg;
  logic step_reg;
  logic grant_reg;
  logic hub_req_reg;
  logic [8:0] ram_addr_reg;
  logic [7:0] clk_mode_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] dval;
  logic [31:0] sval;
  logic [31:0] diff;
  logic [8:0] pc_inc;
  logic cond_ok;
  logic is_jal;
  logic is_mode_set;
  logic is_ucomp;
  logic is_scomp;
  logic hub_op;
  logic fin;
  logic launch;
  logic apb_wr;
  logic core_we;
  logic [31:0] core_wdata;
  logic [31:0] rd_next;
  logic rd_err;

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign hub_req = hub_req_reg;
  assign clk_mode = clk_mode_reg;

  // operand fetch and decode
  assign dval = ram[ir_reg.dst];
  assign sval = ir_reg.imm ? {23'h0, ir_reg.src} : ram[ir_reg.src];
  assign diff = dval - sval;
  assign pc_inc = pc_reg + 9'h001;
  assign cond_ok = ir_reg.cond[{c_reg, z_reg}];
  assign is_jal = ir_reg.op == `CCE_OP_JAL;
  assign is_mode_set = ir_reg.op == `CCE_OP_MODE_SET && ir_reg.imm &&
                       ir_reg.src == 9'h000;
  assign is_ucomp = ir_reg.op == `CCE_OP_UCOMP;
  assign is_scomp = ir_reg.op == `CCE_OP_SCOMP;
  assign hub_op = is_mode_set && cond_ok;
  assign launch = ce && state_reg == cce_pkg::CCE_IDLE &&
                  (run_reg || step_reg);
  // hub op ends once the window came and the minimum time passed
  assign fin = ce && state_reg == cce_pkg::CCE_EXEC &&
               (hub_op ? (grant_reg && cnt_reg >= `CCE_HUB_LAST_CNT)
                       : cnt_reg == `CCE_ALU_LAST_CNT);
  assign apb_wr = ce && psel && penable && pready_reg && pwrite;

  // result write to the register array
  always_comb begin
    core_we = 1'b0;
    core_wdata = diff;
    if (fin && cond_ok && ir_reg.store_res) begin
      if (is_jal) begin
        core_we = 1'b1;
        core_wdata = {dval[31:9], pc_inc};
      end else if (is_ucomp || is_scomp) begin
        core_we = 1'b1;
      end else if (is_mode_set) begin
        core_we = 1'b1;
        core_wdata = {24'h000000, dval[7:0]};
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (ce) begin
      if (core_we) begin
        ram[ir_reg.dst] <= core_wdata;
      end else if (apb_wr && paddr == `CCE_OFF_RAM_DATA) begin
        ram[ram_addr_reg] <= pwdata;
      end
    end
  end

  // sequencer and program counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= cce_pkg::CCE_IDLE;
      ir_reg <= '0;
      pc_reg <= `CCE_PC_RST;
      cnt_reg <= 5'h00;
    end else if (ce) begin
      case (state_reg)
        cce_pkg::CCE_IDLE: begin
          if (launch) begin
            ir_reg <= ram[pc_reg];
            cnt_reg <= 5'h00;
            state_reg <= cce_pkg::CCE_EXEC;
          end else if (apb_wr && paddr == `CCE_OFF_PC) begin
            pc_reg <= pwdata[8:0];
          end
        end
        cce_pkg::CCE_EXEC: begin
          if (cnt_reg != `CCE_CNT_MAX) begin
            cnt_reg <= cnt_reg + 5'h01;
          end
          if (fin) begin
            state_reg <= cce_pkg::CCE_IDLE;
            pc_reg <= (cond_ok && is_jal) ? sval[8:0] : pc_inc;
          end
        end
        default: begin
          state_reg <= cce_pkg::CCE_IDLE;
        end
      endcase
    end
  end

  // hub window request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hub_req_reg <= 1'b0;
      grant_reg <= 1'b0;
    end else if (ce) begin
      if (launch) begin
        hub_req_reg <= 1'b0;
        grant_reg <= 1'b0;
      end else if (state_reg == cce_pkg::CCE_EXEC) begin
        grant_reg <= grant_reg || (hub_req_reg && hub_grant);
        hub_req_reg <= hub_op && !grant_reg && !(hub_req_reg && hub_grant);
      end
    end
  end

  // zero and carry flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      z_reg <= 1'b0;
      c_reg <= 1'b0;
    end else if (fin && cond_ok) begin
      if (ir_reg.upd_z) begin
        if (is_jal) begin
          z_reg <= pc_inc == 9'h000;
        end else if (is_ucomp || is_scomp) begin
          z_reg <= dval == sval;
        end
      end
      if (ir_reg.upd_c) begin
        if (is_jal) begin
          c_reg <= pc_inc != 9'h000;
        end else if (is_ucomp) begin
          c_reg <= dval < sval;
        end else if (is_scomp) begin
          c_reg <= $signed(dval) < $signed(sval);
        end
      end
    end
  end

  // clock mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_mode_reg <= `CCE_CLK_MODE_RST;
    end else if (fin && hub_op) begin
      clk_mode_reg <= dval[7:0];
    end
  end

  // software control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0;
      step_reg <= 1'b0;
      ram_addr_reg <= 9'h000;
    end else if (ce) begin
      if (apb_wr && paddr == `CCE_OFF_CTRL) begin
        run_reg <= pwdata[`CCE_CTRL_RUN];
        step_reg <= pwdata[`CCE_CTRL_STEP] || (step_reg && !launch);
      end else if (launch) begin
        step_reg <= 1'b0;
      end
      if (apb_wr && paddr == `CCE_OFF_RAM_ADDR) begin
        ram_addr_reg <= pwdata[8:0];
      end
    end
  end

  // apb read mux
  always_comb begin
    rd_next = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
      `CCE_OFF_CTRL: rd_next = {30'h00000000, step_reg, run_reg};
      `CCE_OFF_STATUS: rd_next = {7'h00, pc_reg, 12'h000, hub_req_reg,
                                  c_reg, z_reg,
                                  state_reg == cce_pkg::CCE_EXEC};
      `CCE_OFF_PC: rd_next = {23'h000000, pc_reg};
      `CCE_OFF_CLKMODE: rd_next = {24'h000000, clk_mode_reg};
      `CCE_OFF_RAM_ADDR: rd_next = {23'h000000, ram_addr_reg};
      `CCE_OFF_RAM_DATA: rd_next = ram[ram_addr_reg];
      default: rd_err = 1'b1;
    endcase
  end

  // apb answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else if (ce) begin
      pready_reg <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && rd_err;
      if (psel && penable && !pready_reg && !pwrite) begin
        prdata_reg <= rd_next;
      end
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic do_jal;
  logic do_comp;
  logic [31:0] exp_ret;
  assign do_jal = fin && cond_ok && is_jal;
  assign do_comp = fin && cond_ok && (is_ucomp || is_scomp);
  assign exp_ret = {dval[31:9], pc_reg + 9'h001};

  property p_ret_store;
    do_jal && ir_reg.store_res |=> ram[ir_reg.dst] == $past(exp_ret);
  endproperty
  a_ret_store: assert property (p_ret_store)
    else $error("return address not stored");
  property p_jump;
    do_jal |=> {23'h000000, pc_reg} == ($past(sval) & 32'h000001FF);
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target wrong");
  property p_plain_jump;
    do_jal && !ir_reg.store_res |=> ram[ir_reg.dst] == $past(dval);
  endproperty
  a_plain_jump: assert property (p_plain_jump)
    else $error("plain jump wrote register");
  property p_mode;
    fin && hub_op |=> {24'h000000, clk_mode} == ($past(dval) & 32'h000000FF);
  endproperty
  a_mode: assert property (p_mode)
    else $error("clock mode not loaded");
  property p_hub_min;
    $rose(hub_req_reg) |-> (!fin) [*6];
  endproperty
  a_hub_min: assert property (p_hub_min)
    else $error("hub op ended early");
  property p_hub_max;
    $rose(hub_req_reg) |-> ##[0:21] fin;
  endproperty
  a_hub_max: assert property (p_hub_max)
    else $error("hub op over limit");
  property p_alu_time;
    fin && !hub_op |-> $past(launch, 4);
  endproperty
  a_alu_time: assert property (p_alu_time)
    else $error("compare not four clocks");
  property p_zero;
    do_comp && ir_reg.upd_z |=> z_reg == ($past(dval) == $past(sval));
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");
  property p_ucarry;
    do_comp && is_ucomp && ir_reg.upd_c |=>
      c_reg == ($past(dval) < $past(sval));
  endproperty
  a_ucarry: assert property (p_ucarry)
    else $error("unsigned carry wrong");
  property p_keep;
    fin && !ir_reg.upd_z && !ir_reg.upd_c |=> $stable(z_reg) && $stable(c_reg);
  endproperty
  a_keep: assert property (p_keep)
    else $error("flag changed without update");
  property p_diff;
    do_comp && ir_reg.store_res |=>
      ram[ir_reg.dst] == $past(dval) - $past(sval);
  endproperty
  a_diff: assert property (p_diff)
    else $error("difference not written");
  c_call: cover property (do_jal && ir_reg.store_res);
  c_ret: cover property (do_jal && !ir_reg.store_res);
  c_mode: cover property (fin && hub_op);
  c_diff: cover property (do_comp && ir_reg.store_res);
endmodule : cce_exec_core

// ==== tb/cce_hub_model.sv ====
// hub arbiter model granting the core its hub access window
`timescale 1ns/1ps
module cce_hub_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // hub handshake
  input wire logic hub_req,
  input wire logic [4:0] lag,
  output logic hub_grant
);
  logic [4:0] wait_reg;

  // one grant per request, lag cycles after the request is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= 5'h00;
      hub_grant <= 1'b0;
    end else begin
      hub_grant <= hub_req && (wait_reg == lag) && !hub_grant;
      wait_reg <= hub_req ? wait_reg + 5'h01 : 5'h00;
    end
  end
endmodule : cce_hub_model

// ==== tb/cce_exec_core_tb_top.sv ====
// self-checking testbench of the execution core
`timescale 1ns/1ps
`include "cce_consts.svh"
module cce_exec_core_tb_top;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, hub_grant, hub_req;
  logic [7:0] clk_mode;
  logic [4:0] lag;
  int err_total, n_compared;

  cce_exec_core u_cce_exec_core (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hub_grant(hub_grant), .hub_req(hub_req), .clk_mode(clk_mode));
  cce_hub_model u_cce_hub_model (.pclk(pclk), .presetn(presetn),
    .hub_req(hub_req), .lag(lag), .hub_grant(hub_grant));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
  endtask : rd

  task automatic poke(input logic [8:0] r, input logic [31:0] d);
    wr(`CCE_OFF_RAM_ADDR, {23'h000000, r});
    wr(`CCE_OFF_RAM_DATA, d);
  endtask : poke

  task automatic peek(input logic [8:0] r, output logic [31:0] q);
    wr(`CCE_OFF_RAM_ADDR, {23'h000000, r});
    rd(`CCE_OFF_RAM_DATA, q);
  endtask : peek

  // run one instruction at pc and return the status once idle
  task automatic step(input logic [8:0] pc, output logic [31:0] st);
    wr(`CCE_OFF_PC, {23'h000000, pc});
    wr(`CCE_OFF_CTRL, 32'h0000_0002);
    do rd(`CCE_OFF_STATUS, st);
    while (st[0] !== 1'b0);
  endtask : step

  function automatic logic [31:0] ins(input logic [5:0] op,
    input logic [3:0] zcri, input logic [8:0] d, input logic [8:0] s);
    return {op, zcri, 4'hF, d, s};
  endfunction : ins

  task automatic t_comp(input logic [5:0] op, input logic [3:0] zcri,
    input logic [31:0] a, input logic [31:0] b, input logic [1:0] ezc);
    logic [31:0] st, q;
    poke(9'h00A, a);
    poke(9'h00B, b);
    poke(9'h000, ins(op, zcri, 9'h00A, zcri[0] ? b[8:0] : 9'h00B));
    step(9'h000, st);
    chk("zero flag", {31'h0, ezc[1]}, {31'h0, st[1]});
    chk("carry flag", {31'h0, ezc[0]}, {31'h0, st[2]});
    chk("pc", 32'h0000_0001, {23'h000000, st[24:16]});
    peek(9'h00A, q);
    chk("compare dst", zcri[1] ? a - b : a, q);
    $display("test compare done");
  endtask : t_comp

  task automatic t_call();
    logic [31:0] st, q;
    poke(9'h040, ins(`CCE_OP_JAL, 4'h1, 9'h000, 9'h000));
    poke(9'h005, ins(`CCE_OP_JAL, 4'h7, 9'h040, 9'h030));
    step(9'h005, st);
    chk("call pc", 32'h0000_0030, {23'h0, st[24:16]});
    chk("call carry", 32'h0000_0001, {31'h0, st[2]});
    peek(9'h040, q);
    chk("ret addr", ins(`CCE_OP_JAL, 4'h1, 9'h000, 9'h006), q);
    step(9'h040, st);
    chk("ret pc", 32'h0000_0006, {23'h0, st[24:16]});
    poke(9'h007, ins(`CCE_OP_JAL, 4'h1, 9'h040, 9'h031));
    step(9'h007, st);
    chk("jump pc", 32'h0000_0031, {23'h0, st[24:16]});
    peek(9'h040, q);
    chk("no store", ins(`CCE_OP_JAL, 4'h1, 9'h000, 9'h006), q);
    poke(9'h1FF, ins(`CCE_OP_JAL, 4'h7, 9'h040, 9'h030));
    step(9'h1FF, st);
    chk("wrap carry", 32'h0000_0000, {31'h0, st[2]});
    peek(9'h040, q);
    chk("nested", ins(`CCE_OP_JAL, 4'h1, 9'h000, 9'h000), q);
    $display("test call done");
  endtask : t_call

  task automatic t_clk(input logic [4:0] d, input logic [7:0] m,
    input logic [3:0] zcri);
    logic [31:0] st, q;
    lag <= d;
    poke(9'h014, {24'hA5A5A5, m});
    poke(9'h001, ins(`CCE_OP_MODE_SET, zcri, 9'h014, 9'h000));
    step(9'h001, st);
    chk("clock mode", {24'h0, m}, {24'h0, clk_mode});
    chk("hub req", 32'h0000_0000, {31'h0, hub_req});
    rd(`CCE_OFF_CLKMODE, q);
    chk("mode reg", {24'h0, m}, q);
    peek(9'h014, q);
    chk("mode dst", zcri[1] ? {24'h0, m} : {24'hA5A5A5, m}, q);
    $display("test clock mode done");
  endtask : t_clk

  // mode-set opcode without immediate zero source must not load the mode
  task automatic t_no_mode(input logic [7:0] m);
    logic [31:0] st;
    poke(9'h015, 32'h0000_0033);
    poke(9'h002, ins(`CCE_OP_MODE_SET, 4'h0, 9'h015, 9'h000));
    step(9'h002, st);
    chk("no mode reg src", {24'h0, m}, {24'h0, clk_mode});
    chk("no mode pc", 32'h0000_0003, {23'h0, st[24:16]});
    poke(9'h002, ins(`CCE_OP_MODE_SET, 4'h1, 9'h015, 9'h001));
    step(9'h002, st);
    chk("no mode src one", {24'h0, m}, {24'h0, clk_mode});
    $display("test decode done");
  endtask : t_no_mode

  task automatic t_apb();
    logic [31:0] q;
    logic e;
    apb(1'b0, 12'h100, 32'h0000_0000, q, e);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", 32'h0000_0000, q);
    $display("test apb done");
  endtask : t_apb

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    $display("ERROR watchdog expected done seen hang");
    finish_test();
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    lag = 5'h00;
    err_total = 0;
    n_compared = 0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset mode", 32'h0000_0000, {24'h0, clk_mode});
    t_apb();
    t_comp(`CCE_OP_UCOMP, 4'hC, 32'h3, 32'h2, 2'b00);
    t_comp(`CCE_OP_UCOMP, 4'hC, 32'h3, 32'h3, 2'b10);
    t_comp(`CCE_OP_UCOMP, 4'hC, 32'h3, 32'h4, 2'b01);
    t_comp(`CCE_OP_UCOMP, 4'hC, 32'h8000_0000, 32'h7FFF_FFFF, 2'b00);
    t_comp(`CCE_OP_UCOMP, 4'hC, 32'h7FFF_FFFF, 32'h8000_0000, 2'b01);
    t_comp(`CCE_OP_UCOMP, 4'hE, 32'h3, 32'h4, 2'b01);
    t_comp(`CCE_OP_UCOMP, 4'hD, 32'h1FF, 32'h1FF, 2'b10);
    t_comp(`CCE_OP_UCOMP, 4'h0, 32'h3, 32'h4, 2'b10);
    t_comp(`CCE_OP_SCOMP, 4'hC, 32'h8000_0000, 32'h7FFF_FFFF, 2'b01);
    t_comp(`CCE_OP_SCOMP, 4'hC, 32'h7FFF_FFFF, 32'h8000_0000, 2'b00);
    t_call();
    t_clk(5'h00, 8'h6F, 4'h1);
    t_clk(5'h0E, 8'h5A, 4'h3);
    t_no_mode(8'h5A);
    finish_test();
  end
endmodule : cce_exec_core_tb_top
